// ### hdl/motor_guard_pkg.sv
// Constants, register map and types of the motor supply guard and brake sequencer
package motor_guard_pkg;

  // ============================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES_DEFAULT = MS_NS / CLK_PERIOD_NS;

  // ============================================================
  // Register offsets (word addresses on the register port)
  localparam logic [15:0] OFS_OV_THRESHOLD = 16'h2034;
  localparam logic [15:0] OFS_UV_THRESHOLD = 16'h2035;
  localparam logic [15:0] OFS_RED_IDLE = 16'h2036;
  localparam logic [15:0] OFS_RED_TARGET = 16'h2037;
  localparam logic [15:0] OFS_CURRENT_0 = 16'h2039;
  localparam logic [15:0] OFS_CURRENT_1 = 16'h2048;
  localparam logic [15:0] OFS_CURRENT_2 = 16'h2049;
  localparam logic [15:0] OFS_CURRENT_3 = 16'h204a;
  localparam logic [15:0] OFS_BRAKE_COUNT = 16'h2040;
  localparam logic [15:0] OFS_BRAKE_CLOSE = 16'h2041;
  localparam logic [15:0] OFS_POWER_OFF = 16'h2042;
  localparam logic [15:0] OFS_BRAKE_OPEN = 16'h2043;
  localparam logic [15:0] OFS_RUN_START = 16'h2044;
  localparam logic [15:0] OFS_PWM_FREQ = 16'h2045;
  localparam logic [15:0] OFS_PWM_DUTY = 16'h2046;
  localparam logic [15:0] OFS_IRQ_STATUS = 16'h2050;
  localparam logic [15:0] OFS_IRQ_CLEAR = 16'h2051;
  localparam logic [15:0] OFS_IRQ_ENABLE = 16'h2052;
  localparam logic [15:0] OFS_DRIVE_CFG = 16'h2053;

  // ============================================================
  // Reset values
  localparam logic [31:0] RST_OV_THRESHOLD = 32'h0000c544;
  localparam logic [31:0] RST_UV_THRESHOLD = 32'h00004650;
  localparam logic [31:0] RST_RED_IDLE = 32'h000003e8;
  localparam logic [31:0] RST_RED_TARGET = 32'h0fffffce;
  localparam logic [7:0] RST_BRAKE_COUNT = 8'h06;
  localparam logic [31:0] RST_BRAKE_CLOSE = 32'h000003e8;
  localparam logic [31:0] RST_POWER_OFF = 32'h000003e8;
  localparam logic [31:0] RST_BRAKE_OPEN = 32'h000003e8;
  localparam logic [31:0] RST_RUN_START = 32'h00000000;
  localparam logic [31:0] RST_PWM_FREQ = 32'h00000000;
  localparam logic [31:0] RST_PWM_DUTY = 32'h00000000;

  // ============================================================
  // Limits and fields
  localparam logic [31:0] OV_HYST_MV = 32'h000007d0;
  localparam logic [31:0] UV_HYST_MV = 32'h000005dc;
  localparam logic [31:0] PWM_FREQ_MAX = 32'h000007d0;
  localparam logic [31:0] PWM_DUTY_MIN = 32'h00000002;
  localparam logic [31:0] PWM_DUTY_MAX = 32'h00000064;
  localparam int CFG_RED_ENABLE_BIT = 3;
  localparam int IRQ_BITS = 4;
  localparam int IRQ_OV = 0;
  localparam int IRQ_UV = 1;
  localparam int IRQ_BRAKE_CLOSED = 2;
  localparam int IRQ_RUN_REACHED = 3;
  // Square root of two in Q15
  localparam logic [48:0] SQRT2_Q15 = 49'h0000_0000_b505;
  localparam int SQRT2_SHIFT = 15;

  // ============================================================
  // Brake sequence states, Gray coded along the close and open path except the step from start wait back to run
  typedef enum logic [2:0] {
    SEQ_RUN = 3'h0,
    SEQ_CLOSE_WAIT = 3'h1,
    SEQ_OFF_WAIT = 3'h3,
    SEQ_OFF = 3'h2,
    SEQ_OPEN_WAIT = 3'h6,
    SEQ_START_WAIT = 3'h7
  } seq_state_type;

endpackage

// ### hdl/motor_guard.sv
// Supply guard, standstill current reduction, brake sequencer and current report
// Operation
// - Supply above upper threshold switches drive off and raises overvoltage error.
// - Overvoltage error clears itself below upper threshold minus two volts.
// - Supply below lower threshold switches drive off and raises undervoltage error.
// - Undervoltage error clears itself above lower threshold plus 1.5 volts.
// - Reduction starts only after standstill lasted the programmed idle milliseconds.
// - Reduction only in open loop and with configuration bit 3 set.
// - Setting from zero up to below rated current is the reduced current.
// - Setting -1 to -100 gives rated times (setting plus 100) over 100.
// - Setting -100 gives zero reduced current.
// - After standstill wait close-brake idle time, then engage brake.
// - After engaging brake wait power-off idle time, then switch current off.
// - After switching current on wait open-brake delay, then release brake.
// - After releasing brake wait start delay, then enter operation enabled.
// - Brake PWM runs at programmed frequency, 0 to 2000 hertz accepted.
// - Brake PWM duty follows programmed percent, 0 or 2 to 100 accepted.
// - Currents are reported as signed milliampere peak values, rms times root two.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module motor_guard #(
  parameter int MS_CYCLES = motor_guard_pkg::MS_CYCLES_DEFAULT,
  parameter logic [31:0] OV_DEFAULT_MV = motor_guard_pkg::RST_OV_THRESHOLD
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [15:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Measurements and drive status
  input wire logic [31:0] i_supply_mv,
  input wire logic [31:0] i_rated_current_ma,
  input wire logic signed [31:0] i_current_rms [4],
  input wire logic i_standstill,
  input wire logic i_open_loop,
  input wire logic i_enable_req,
  // Drive control
  output logic o_overvoltage,
  output logic o_undervoltage,
  output logic o_drive_off,
  output logic o_reduce_active,
  output logic [31:0] o_reduced_current_ma,
  output logic o_motor_current_on,
  output logic o_brake_release,
  output logic o_brake_out,
  output logic o_operation_enabled,
  output logic o_irq
);

  // ============================================================
  // Decoding and scaling
  function automatic logic addr_is(input logic [15:0] a, input logic [15:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic [31:0] scale_peak(input logic signed [31:0] rms);
    logic signed [48:0] p;
    p = 49'(rms) * $signed(motor_guard_pkg::SQRT2_Q15);
    return p[motor_guard_pkg::SQRT2_SHIFT +: 32];
  endfunction

  // ============================================================
  // Register file
  logic [31:0] ov_th, uv_th, red_idle, red_target;
  logic [31:0] close_ms, off_ms, open_ms, start_ms, pwm_freq, pwm_duty;
  logic [31:0] drive_cfg;
  logic [motor_guard_pkg::IRQ_BITS-1:0] irq_status, irq_enable, irq_event;
  logic [31:0] peak [4];
  logic [31:0] next_ov_th, next_uv_th, next_red_idle, next_red_target;
  logic [31:0] next_close_ms, next_off_ms, next_open_ms, next_start_ms;
  logic [31:0] next_pwm_freq, next_pwm_duty, next_drive_cfg, next_rdata;
  logic [motor_guard_pkg::IRQ_BITS-1:0] next_irq_status, next_irq_enable;
  logic next_irq;

  always_comb begin
    next_ov_th = ov_th;
    next_uv_th = uv_th;
    next_red_idle = red_idle;
    next_red_target = red_target;
    next_close_ms = close_ms;
    next_off_ms = off_ms;
    next_open_ms = open_ms;
    next_start_ms = start_ms;
    next_pwm_freq = pwm_freq;
    next_pwm_duty = pwm_duty;
    next_drive_cfg = drive_cfg;
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    if (i_wr) begin
      if (addr_is(i_addr, motor_guard_pkg::OFS_OV_THRESHOLD)) next_ov_th = i_wdata;
      if (addr_is(i_addr, motor_guard_pkg::OFS_UV_THRESHOLD)) next_uv_th = i_wdata;
      if (addr_is(i_addr, motor_guard_pkg::OFS_RED_IDLE)) next_red_idle = i_wdata;
      if (addr_is(i_addr, motor_guard_pkg::OFS_RED_TARGET)) next_red_target = i_wdata;
      if (addr_is(i_addr, motor_guard_pkg::OFS_BRAKE_CLOSE)) next_close_ms = i_wdata;
      if (addr_is(i_addr, motor_guard_pkg::OFS_POWER_OFF)) next_off_ms = i_wdata;
      if (addr_is(i_addr, motor_guard_pkg::OFS_BRAKE_OPEN)) next_open_ms = i_wdata;
      if (addr_is(i_addr, motor_guard_pkg::OFS_RUN_START)) next_start_ms = i_wdata;
      // Out-of-range PWM settings are refused and the old value stays
      if (addr_is(i_addr, motor_guard_pkg::OFS_PWM_FREQ)
          && i_wdata <= motor_guard_pkg::PWM_FREQ_MAX) begin
        next_pwm_freq = i_wdata;
      end
      if (addr_is(i_addr, motor_guard_pkg::OFS_PWM_DUTY) && (i_wdata == 32'h0
          || (i_wdata >= motor_guard_pkg::PWM_DUTY_MIN
          && i_wdata <= motor_guard_pkg::PWM_DUTY_MAX))) begin
        next_pwm_duty = i_wdata;
      end
      if (addr_is(i_addr, motor_guard_pkg::OFS_DRIVE_CFG)) next_drive_cfg = i_wdata;
      if (addr_is(i_addr, motor_guard_pkg::OFS_IRQ_ENABLE)) begin
        next_irq_enable = i_wdata[motor_guard_pkg::IRQ_BITS-1:0];
      end
      if (addr_is(i_addr, motor_guard_pkg::OFS_IRQ_CLEAR)) begin
        next_irq_status = irq_status & ~i_wdata[motor_guard_pkg::IRQ_BITS-1:0];
      end
    end
    // A new event wins over a clear in the same cycle
    next_irq_status = next_irq_status | irq_event;
    next_irq = |(next_irq_status & next_irq_enable);
    next_rdata = 32'h0;
    if (i_rd) begin
      case (i_addr)
        motor_guard_pkg::OFS_OV_THRESHOLD: next_rdata = ov_th;
        motor_guard_pkg::OFS_UV_THRESHOLD: next_rdata = uv_th;
        motor_guard_pkg::OFS_RED_IDLE: next_rdata = red_idle;
        motor_guard_pkg::OFS_RED_TARGET: next_rdata = red_target;
        motor_guard_pkg::OFS_CURRENT_0: next_rdata = peak[0];
        motor_guard_pkg::OFS_CURRENT_1: next_rdata = peak[1];
        motor_guard_pkg::OFS_CURRENT_2: next_rdata = peak[2];
        motor_guard_pkg::OFS_CURRENT_3: next_rdata = peak[3];
        motor_guard_pkg::OFS_BRAKE_COUNT: next_rdata = {24'h0, motor_guard_pkg::RST_BRAKE_COUNT};
        motor_guard_pkg::OFS_BRAKE_CLOSE: next_rdata = close_ms;
        motor_guard_pkg::OFS_POWER_OFF: next_rdata = off_ms;
        motor_guard_pkg::OFS_BRAKE_OPEN: next_rdata = open_ms;
        motor_guard_pkg::OFS_RUN_START: next_rdata = start_ms;
        motor_guard_pkg::OFS_PWM_FREQ: next_rdata = pwm_freq;
        motor_guard_pkg::OFS_PWM_DUTY: next_rdata = pwm_duty;
        motor_guard_pkg::OFS_IRQ_STATUS: next_rdata = 32'(irq_status);
        motor_guard_pkg::OFS_IRQ_ENABLE: next_rdata = 32'(irq_enable);
        motor_guard_pkg::OFS_DRIVE_CFG: next_rdata = drive_cfg;
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ov_th <= OV_DEFAULT_MV;
      uv_th <= motor_guard_pkg::RST_UV_THRESHOLD;
      red_idle <= motor_guard_pkg::RST_RED_IDLE;
      red_target <= motor_guard_pkg::RST_RED_TARGET;
      close_ms <= motor_guard_pkg::RST_BRAKE_CLOSE;
      off_ms <= motor_guard_pkg::RST_POWER_OFF;
      open_ms <= motor_guard_pkg::RST_BRAKE_OPEN;
      start_ms <= motor_guard_pkg::RST_RUN_START;
      pwm_freq <= motor_guard_pkg::RST_PWM_FREQ;
      pwm_duty <= motor_guard_pkg::RST_PWM_DUTY;
      drive_cfg <= 32'h0;
      irq_status <= '0;
      irq_enable <= '0;
      o_irq <= 1'b0;
      o_rdata <= 32'h0;
    end else begin
      ov_th <= next_ov_th;
      uv_th <= next_uv_th;
      red_idle <= next_red_idle;
      red_target <= next_red_target;
      close_ms <= next_close_ms;
      off_ms <= next_off_ms;
      open_ms <= next_open_ms;
      start_ms <= next_start_ms;
      pwm_freq <= next_pwm_freq;
      pwm_duty <= next_pwm_duty;
      drive_cfg <= next_drive_cfg;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      o_irq <= next_irq;
      o_rdata <= next_rdata;
    end
  end

  // ============================================================
  // Current report, one scaler per channel
  for (genvar g = 0; g < 4; g++) begin : g_peak
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        peak[g] <= 32'h0;
      end else begin
        peak[g] <= scale_peak(i_current_rms[g]);
      end
    end
  end

  // ============================================================
  // Supply supervision
  logic next_ov, next_uv;

  always_comb begin
    next_ov = o_overvoltage;
    next_uv = o_undervoltage;
    if (i_supply_mv > ov_th) begin
      next_ov = 1'b1;
    end else if (i_supply_mv < ov_th - motor_guard_pkg::OV_HYST_MV) begin
      next_ov = 1'b0;
    end
    if (i_supply_mv < uv_th) begin
      next_uv = 1'b1;
    end else if (i_supply_mv > uv_th + motor_guard_pkg::UV_HYST_MV) begin
      next_uv = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_overvoltage <= 1'b0;
      o_undervoltage <= 1'b0;
      o_drive_off <= 1'b0;
    end else begin
      o_overvoltage <= next_ov;
      o_undervoltage <= next_uv;
      o_drive_off <= next_ov | next_uv;
    end
  end

  // ============================================================
  // Standstill current reduction
  logic [31:0] red_pre, red_ms, next_red_pre, next_red_ms, next_red_current;
  logic red_allowed, red_valid, next_red_active;
  logic signed [31:0] red_set;
  logic [6:0] red_pct;
  logic [38:0] red_prod;

  always_comb begin
    red_set = $signed(red_target);
    red_allowed = i_standstill && i_open_loop
        && drive_cfg[motor_guard_pkg::CFG_RED_ENABLE_BIT];
    red_pct = 7'(red_set + 32'sd100);
    red_prod = 39'(i_rated_current_ma) * 39'(red_pct);
    red_valid = 1'b0;
    next_red_current = o_reduced_current_ma;
    if (red_set >= 32'sd0 && red_target < i_rated_current_ma) begin
      red_valid = 1'b1;
      next_red_current = red_target;
    end else if (red_set <= -32'sd1 && red_set >= -32'sd100) begin
      red_valid = 1'b1;
      // Setting -100 gives a zero factor and so zero current
      next_red_current = 32'(red_prod / 39'd100);
    end
    next_red_pre = 32'h0;
    next_red_ms = 32'h0;
    if (red_allowed) begin
      next_red_pre = (red_pre == 32'(MS_CYCLES - 1)) ? 32'h0 : red_pre + 32'h1;
      next_red_ms = red_ms;
      if (red_pre == 32'(MS_CYCLES - 1) && red_ms != 32'hffffffff) begin
        next_red_ms = red_ms + 32'h1;
      end
    end
    next_red_active = red_allowed && red_valid && next_red_ms >= red_idle;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      red_pre <= 32'h0;
      red_ms <= 32'h0;
      o_reduce_active <= 1'b0;
      o_reduced_current_ma <= 32'h0;
    end else begin
      red_pre <= next_red_pre;
      red_ms <= next_red_ms;
      o_reduce_active <= next_red_active;
      o_reduced_current_ma <= next_red_current;
    end
  end

  // ============================================================
  // Brake sequence
  motor_guard_pkg::seq_state_type state, next_state;
  logic [31:0] seq_pre, seq_ms, next_seq_pre, next_seq_ms;
  logic [31:0] lat_a, lat_b, next_lat_a, next_lat_b, wait_ms;
  logic next_cur_on, next_release, next_run, seq_done;

  always_comb begin
    next_state = state;
    next_lat_a = lat_a;
    next_lat_b = lat_b;
    // First and second delay of whichever half is running
    wait_ms = (state == motor_guard_pkg::SEQ_CLOSE_WAIT
        || state == motor_guard_pkg::SEQ_OPEN_WAIT) ? lat_a : lat_b;
    seq_done = seq_ms >= wait_ms;
    next_seq_pre = (seq_pre == 32'(MS_CYCLES - 1)) ? 32'h0 : seq_pre + 32'h1;
    next_seq_ms = (seq_pre == 32'(MS_CYCLES - 1)) ? seq_ms + 32'h1 : seq_ms;
    irq_event = '0;
    irq_event[motor_guard_pkg::IRQ_OV] = !o_overvoltage && next_ov;
    irq_event[motor_guard_pkg::IRQ_UV] = !o_undervoltage && next_uv;
    case (state)
      motor_guard_pkg::SEQ_RUN: begin
        if (!i_enable_req && i_standstill) begin
          next_state = motor_guard_pkg::SEQ_CLOSE_WAIT;
          next_lat_a = close_ms;
          next_lat_b = off_ms;
        end
      end
      motor_guard_pkg::SEQ_CLOSE_WAIT: begin
        if (seq_done) begin
          next_state = motor_guard_pkg::SEQ_OFF_WAIT;
          irq_event[motor_guard_pkg::IRQ_BRAKE_CLOSED] = 1'b1;
        end
      end
      motor_guard_pkg::SEQ_OFF_WAIT: begin
        if (seq_done) next_state = motor_guard_pkg::SEQ_OFF;
      end
      motor_guard_pkg::SEQ_OFF: begin
        if (i_enable_req && !o_drive_off) begin
          next_state = motor_guard_pkg::SEQ_OPEN_WAIT;
          next_lat_a = open_ms;
          next_lat_b = start_ms;
        end
      end
      motor_guard_pkg::SEQ_OPEN_WAIT: begin
        if (seq_done) next_state = motor_guard_pkg::SEQ_START_WAIT;
      end
      motor_guard_pkg::SEQ_START_WAIT: begin
        if (seq_done) begin
          next_state = motor_guard_pkg::SEQ_RUN;
          irq_event[motor_guard_pkg::IRQ_RUN_REACHED] = 1'b1;
        end
      end
      default: next_state = motor_guard_pkg::SEQ_OFF;
    endcase
    // The millisecond count restarts at every step of the sequence
    if (next_state != state) begin
      next_seq_pre = 32'h0;
      next_seq_ms = 32'h0;
    end
    next_cur_on = next_state != motor_guard_pkg::SEQ_OFF && !(next_ov | next_uv);
    next_release = next_state == motor_guard_pkg::SEQ_RUN
        || next_state == motor_guard_pkg::SEQ_CLOSE_WAIT
        || next_state == motor_guard_pkg::SEQ_START_WAIT;
    next_release = next_release && next_cur_on;
    next_run = next_state == motor_guard_pkg::SEQ_RUN && next_cur_on;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= motor_guard_pkg::SEQ_OFF;
      seq_pre <= 32'h0;
      seq_ms <= 32'h0;
      lat_a <= 32'h0;
      lat_b <= 32'h0;
      o_motor_current_on <= 1'b0;
      o_brake_release <= 1'b0;
      o_operation_enabled <= 1'b0;
    end else begin
      state <= next_state;
      seq_pre <= next_seq_pre;
      seq_ms <= next_seq_ms;
      lat_a <= next_lat_a;
      lat_b <= next_lat_b;
      o_motor_current_on <= next_cur_on;
      o_brake_release <= next_release;
      o_operation_enabled <= next_run;
    end
  end

  // ============================================================
  // Brake PWM: phase accumulator stepping by the frequency, wrapping at the clock rate
  logic [31:0] pwm_acc, next_pwm_acc;
  logic next_brake_out;

  always_comb begin
    next_pwm_acc = pwm_acc + pwm_freq;
    if (next_pwm_acc >= 32'(motor_guard_pkg::CLK_HZ)) begin
      next_pwm_acc = next_pwm_acc - 32'(motor_guard_pkg::CLK_HZ);
    end
    // Zero frequency or zero duty drives the brake steadily
    if (pwm_freq == 32'h0 || pwm_duty == 32'h0) begin
      next_brake_out = next_release;
    end else begin
      next_brake_out = next_release
          && (pwm_acc * 32'd100 < pwm_duty * 32'(motor_guard_pkg::CLK_HZ));
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pwm_acc <= 32'h0;
      o_brake_out <= 1'b0;
    end else begin
      pwm_acc <= next_pwm_acc;
      o_brake_out <= next_brake_out;
    end
  end

  // ============================================================
  // Assertions
  a_ov_trip: assert property (@(posedge i_clk) disable iff (i_rst)
    i_supply_mv > ov_th |=> o_overvoltage && o_drive_off) else $error("ov not raised");
  a_ov_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    i_supply_mv < ov_th - motor_guard_pkg::OV_HYST_MV |=> !o_overvoltage)
    else $error("ov not cleared");
  a_ov_hyst: assert property (@(posedge i_clk) disable iff (i_rst)
    o_overvoltage && i_supply_mv >= ov_th - motor_guard_pkg::OV_HYST_MV |=> o_overvoltage)
    else $error("ov dropped inside hysteresis");
  a_uv_trip: assert property (@(posedge i_clk) disable iff (i_rst)
    i_supply_mv < uv_th |=> o_undervoltage && o_drive_off) else $error("uv not raised");
  a_uv_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    i_supply_mv > uv_th + motor_guard_pkg::UV_HYST_MV |=> !o_undervoltage)
    else $error("uv not cleared");
  a_red_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    o_reduce_active |-> $past(i_open_loop) && $past(i_standstill) && red_ms >= red_idle)
    else $error("reduction without cause");
  a_red_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    red_target == 32'hffffff9c |=> o_reduced_current_ma == 32'h0)
    else $error("minus 100 not zero");
  a_brake_first: assert property (@(posedge i_clk) disable iff (i_rst)
    o_brake_release |-> o_motor_current_on) else $error("brake open without current");
  a_run_order: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_operation_enabled) |-> $past(state) == motor_guard_pkg::SEQ_START_WAIT
    && $past(seq_ms) >= lat_b) else $error("run reached early");
  a_close_time: assert property (@(posedge i_clk) disable iff (i_rst)
    state == motor_guard_pkg::SEQ_CLOSE_WAIT && seq_ms < lat_a
    |=> state != motor_guard_pkg::SEQ_OFF_WAIT) else $error("brake closed early");
  a_off_time: assert property (@(posedge i_clk) disable iff (i_rst)
    state == motor_guard_pkg::SEQ_OFF_WAIT && seq_ms < lat_b
    |=> state == motor_guard_pkg::SEQ_OFF_WAIT) else $error("current off early");
  a_pwm_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    o_brake_out |-> o_brake_release) else $error("brake pwm while engaged");
  c_ov_trip: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_overvoltage));
  c_reduce: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_reduce_active));
  c_closed: cover property (@(posedge i_clk) disable iff (i_rst)
    state == motor_guard_pkg::SEQ_OFF_WAIT ##1 state == motor_guard_pkg::SEQ_OFF);
  c_run: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_operation_enabled));

endmodule // motor_guard

`default_nettype wire

// ### test/motor_guard_bench.sv
// Self-checking bench of the motor supply guard and brake sequencer
`timescale 1ns/1ps
`default_nettype none
module motor_guard_bench;
  // ============================================================
  // Stimulus and observed ports
  logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, stand = 0, ol = 0, en = 0;
  logic [15:0] i_addr = 16'h0;
  logic [31:0] i_wdata = 32'h0, sup = 32'h5dc0, rated = 32'h1068, o_rdata, redma;
  logic signed [31:0] cur [4] = '{default: 0};
  logic ov, uv, off, red, con, rel, bo, run, irq;
  int miscompares = 0, tests_run = 0, r, n, cv [4];
  logic [15:0] co [4] = '{16'h2039, 16'h2048, 16'h2049, 16'h204a};
  logic [15:0] ra [8] = '{16'h2034, 16'h2035, 16'h2036, 16'h2037, 16'h2040, 16'h2041,
    16'h2044, 16'h2060};
  logic [31:0] rv [8] = '{32'hc544, 32'h4650, 32'h3e8, 32'hfffffce, 32'h6, 32'h3e8, 32'h0,
    32'h0};
  always #50 i_clk = ~i_clk;
  // Short millisecond so the brake and idle delays stay a few cycles long
  motor_guard #(.MS_CYCLES(4)) i_dut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_supply_mv(sup), .i_rated_current_ma(rated), .i_current_rms(cur),
    .i_standstill(stand), .i_open_loop(ol), .i_enable_req(en), .o_overvoltage(ov),
    .o_undervoltage(uv), .o_drive_off(off), .o_reduce_active(red),
    .o_reduced_current_ma(redma), .o_motor_current_on(con), .o_brake_release(rel),
    .o_brake_out(bo), .o_operation_enabled(run), .o_irq(irq));
  // ============================================================
  // Bus and compare tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata, e);
  endtask
  task automatic sv(input logic [31:0] v);
    @(posedge i_clk);
    sup <= v;
    wt(2);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    miscompares++;
    complete_run();
  end
  // ============================================================
  // Tests
  initial begin
    r = $urandom(32'h3945);
    wt(8);
    @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(16'h2040, 32'h9);
    rd(16'h2040, 32'h6);
    wr(16'h2045, 32'h7d1);
    rd(16'h2045, 32'h0);
    wr(16'h2045, 32'h7d0);
    rd(16'h2045, 32'h7d0);
    wr(16'h2046, 32'h1);
    rd(16'h2046, 32'h0);
    wr(16'h2046, 32'h64);
    rd(16'h2046, 32'h64);
    $display("test registers done");
    wr(16'h2043, 32'h1);
    @(posedge i_clk);
    en <= 1'b1;
    wt(2);
    chk({con, rel}, 32'h2);
    wt(8);
    chk({rel, run, bo}, 32'h7);
    // Half duty at 2000 Hz: 2500 high cycles in one 5000-cycle period
    wr(16'h2046, 32'h32);
    wt(1);
    n = 0;
    repeat (5000) @(negedge i_clk) n += bo;
    chk(n, 32'h9c4);
    wr(16'h2041, 32'h0);
    wr(16'h2042, 32'h0);
    @(posedge i_clk);
    en <= 1'b0;
    stand <= 1'b1;
    wt(8);
    chk({con, rel, run}, 32'h0);
    $display("test brake done");
    wr(16'h2051, 32'hf);
    wr(16'h2052, 32'h1);
    sv(32'hc545);
    chk({ov, off, irq}, 32'h7);
    sv(32'hbd74);
    chk(ov, 32'h1);
    sv(32'hbd73);
    chk({ov, irq}, 32'h1);
    wr(16'h2051, 32'h1);
    wt(2);
    chk(irq, 32'h0);
    sv(32'h464f);
    chk({uv, off}, 32'h3);
    sv(32'h4c2c);
    chk(uv, 32'h1);
    sv(32'h4c2d);
    chk({uv, off}, 32'h0);
    rd(16'h2050, 32'h2);
    rd(16'h2052, 32'h1);
    $display("test supply done");
    wr(16'h2053, 32'h8);
    wr(16'h2036, 32'h1);
    wr(16'h2037, 32'hffffffc4);
    @(posedge i_clk);
    ol <= 1'b1;
    wt(2);
    chk(red, 32'h0);
    wt(8);
    chk(red, 32'h1);
    chk(redma, 32'h690);
    @(posedge i_clk);
    ol <= 1'b0;
    wt(2);
    chk(red, 32'h0);
    wr(16'h2037, 32'hffffff9c);
    @(posedge i_clk);
    ol <= 1'b1;
    wt(10);
    chk(red, 32'h1);
    chk(redma, 32'h0);
    wr(16'h2037, 32'h3e8);
    wt(2);
    chk(redma, 32'h3e8);
    chk(red, 32'h1);
    $display("test reduction done");
    foreach (cur[i]) begin
      @(posedge i_clk);
      cv[i] = int'($urandom % 40000) - 20000;
      cur[i] <= cv[i];
    end
    wt(2);
    foreach (co[i]) rd(co[i], (cv[i] * 46341) >>> 15);
    $display("test currents done");
    complete_run();
  end
endmodule // motor_guard_bench
`default_nettype wire
